// [core/dcv_regs.svh]
/*
 * Register offsets, field positions and reset values of the four-channel
 * DMA control and vectoring block.
 * Assumes a byte-wide register port with a 7-bit byte address.
 */
`ifndef DCV_REGS_SVH
`define DCV_REGS_SVH

`define DCV_CH_STRIDE_SH  5
`define DCV_OFF_CTL_LOW   5'h00
`define DCV_OFF_CTL_MID   5'h01
`define DCV_OFF_CTL_HIGH  5'h02
`define DCV_OFF_PATTERN   5'h04
`define DCV_OFF_MASK      5'h08
`define DCV_OFF_SRC_LO    5'h0C
`define DCV_OFF_DST_LO    5'h10
`define DCV_OFF_CNT_LO    5'h14
`define DCV_OFF_CONFIG    7'h78
`define DCV_OFF_PEEK_VEC  7'h5C
`define DCV_OFF_ACK_VEC   7'h7C
`define DCV_OFF_FLAGS_LO  7'h7E
`define DCV_OFF_FLAGS_HI  7'h7F

// control word bit positions
`define DCV_B_OP          0
`define DCV_B_FLYBY       2
`define DCV_B_INCLUSIVE   3
`define DCV_B_SENSE       4
`define DCV_B_PRI_KIND    5
`define DCV_B_PRI_FREEZE  6
`define DCV_B_AUTO        7
`define DCV_B_SRC_KIND    8
`define DCV_B_SRC_SIDE    9
`define DCV_B_SRC_WIDTH   10
`define DCV_B_SRC_DOWN    11
`define DCV_B_DST_KIND    12
`define DCV_B_DST_SIDE    13
`define DCV_B_DST_WIDTH   14
`define DCV_B_DST_DOWN    15
`define DCV_B_BURST       17
`define DCV_B_ON_DONE     18
`define DCV_B_ON_HIT      19
`define DCV_B_DONE_IE     21
`define DCV_B_HIT_IE      22
`define DCV_B_HALT_IE     23

// event nibble bit positions
`define DCV_F_DONE        0
`define DCV_F_HIT         1
`define DCV_F_HALT        2
`define DCV_F_SEVERAL     3

`define DCV_RST_CTL       24'h000000
`define DCV_RST_MASK      8'h00
`define DCV_RST_BIAS      5'h00
`define DCV_RST_CONFIG    8'h00

`endif

// [core/dcv_pkg.sv]
/*
 * Types shared by the DMA control and vectoring block.
 * Assumes dcv_regs.svh carries the numeric constants.
 */
`default_nettype none
package dcv_pkg;
   typedef enum logic [1:0] {
      OP_OFF,
      OP_SEARCH,
      OP_MOVE,
      OP_MOVE_SEARCH
   } dcv_op_t;

   typedef enum logic [1:0] {
      HS_IDLE,
      HS_LOW1,
      HS_LOW2,
      HS_LONG
   } dcv_halt_st_t;

   typedef enum logic [1:0] {
      HIT_DISABLE,
      HIT_CONTINUE,
      HIT_LOAD_CTL,
      HIT_LOAD_ALL
   } dcv_hit_act_t;
endpackage : dcv_pkg
`default_nettype wire

// [core/dcv_dma_core.sv]
/*
 * Four-channel DMA register file, transfer sequencing, event flags and
 * interrupt vector logic.
 * Assumes a synchronous byte register port (chip select, read and write
 * strobes) and a transfer engine that pulses xfer_done_in per beat.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dcv_regs.svh"

// Overview of operation
// - vector byte: channel in bits 1:0, error bit 2, bias bits 7:3
// - error bit set when a channel interrupts again before service
// - writing the vector register stores its upper five bits as bias
// - vector reads toggle service flip-flop; reset or write clears it
// - acknowledge drops interrupt unless a higher channel still pends
// - no new acknowledge until previous return cycle is done
// - peek vector mirrors vector, read-only, no side effects
// - status read clears bits except enabled ones and, while the channel pends, several; cleared on acknowledge
// - status holds one nibble per channel: done, hit, halted, several
// - done at count end or on a hit not set to continue; hit on match; halted on halt pin
// - several flag when more than one channel event occurred
// - op code: off, search, transfer, transfer and search; reset clears
// - low byte bits: flyby, inclusive, while, priority kind, freeze, auto
// - mid byte low nibble: source kind, side, width, step down
// - mid byte high nibble: same four target attributes
// - high byte: burst select, chain on done, bit 0 reserved
// - action after hit: disable, continue, load control, load all
// - high byte bits 5..7 enable done, hit and halt interrupts
// - compare only bits whose mask is one; mask zero after reset
// - pointers fixed for peripherals, step one or two for memory
// - count steps down one or two; zero write stops transfer
// - halt pin low one or two clocks halts; longer resets control, mask, flags, vector
module dcv_dma_core (
   input  wire logic        mclk_in,
   input  wire logic        reset_in,
   input  wire logic        reset_halt_n_in,
   input  wire logic        cs_n_in,
   input  wire logic        rd_in,
   input  wire logic        wr_in,
   input  wire logic [6:0]  addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic [3:0]  req_in,
   input  wire logic        xfer_done_in,
   input  wire logic [7:0]  xfer_data_in,
   output logic      [7:0]  rdata_out,
   output logic             irq_n_out,
   output logic      [3:0]  chan_ack_out,
   output logic      [23:0] src_addr_out,
   output logic      [23:0] dst_addr_out
);
   logic [23:0] ctl_r [4];
   logic [23:0] ctl_nxt [4];
   logic [7:0]  pat_r [4];
   logic [7:0]  pat_nxt [4];
   logic [7:0]  msk_r [4];
   logic [7:0]  msk_nxt [4];
   logic [23:0] src_r [4];
   logic [23:0] src_nxt [4];
   logic [23:0] dst_r [4];
   logic [23:0] dst_nxt [4];
   logic [15:0] cnt_r [4];
   logic [15:0] cnt_nxt [4];
   logic [15:0] flags_r, flags_nxt;
   logic [3:0]  err_r, err_nxt;
   logic [4:0]  bias_r, bias_nxt;
   logic [7:0]  cfg_r, cfg_nxt;
   logic        svc_ff_r, in_svc_r;
   logic [1:0]  svc_ch_r;
   logic [3:0]  gnt_r, gnt_nxt;
   logic [3:0]  gap_r, gap_nxt;
   logic [7:0]  rdat_r;
   logic        irq_n_r;
   logic [23:0] src_q_r, dst_q_r;
   dcv_pkg::dcv_halt_st_t hs_r, hs_nxt;

   // register port decode
   wire        wr_hit   = ~cs_n_in & wr_in;
   wire        rd_hit   = ~cs_n_in & rd_in;
   wire [1:0]  a_ch     = addr_in[6:5];
   wire [4:0]  a_sub    = addr_in[4:0];
   wire        is_ack   = addr_in == `DCV_OFF_ACK_VEC;
   wire        is_peek  = addr_in == `DCV_OFF_PEEK_VEC;
   wire        is_cfg   = addr_in == `DCV_OFF_CONFIG;
   wire        is_flo   = addr_in == `DCV_OFF_FLAGS_LO;
   wire        is_fhi   = addr_in == `DCV_OFF_FLAGS_HI;
   wire        is_glob  = is_ack | is_peek | is_cfg | is_flo | is_fhi;
   wire        ack_rd   = rd_hit & is_ack & ~svc_ff_r;
   wire        ret_rd   = rd_hit & is_ack & svc_ff_r;

   // halt pin filter: short pulse halts, long low resets control, mask and status
   wire        halt_pls = ((hs_r == dcv_pkg::HS_LOW1) | (hs_r == dcv_pkg::HS_LOW2))
                          & reset_halt_n_in;
   wire        soft_rst = hs_r == dcv_pkg::HS_LONG;

   // interrupt enables and pending per channel
   logic [3:0] pend, pend_nxt;
   logic [2:0] ien [4];
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         ien[i]      = ctl_r[i][`DCV_B_HALT_IE:`DCV_B_DONE_IE];
         pend[i]     = |(flags_r[4*i +: 3] & ien[i]);
         pend_nxt[i] = |(flags_nxt[4*i +: 3] & ien[i]);
      end
   end
   wire [1:0] top_ch = pend[0] ? 2'h0 : pend[1] ? 2'h1 : pend[2] ? 2'h2 : 2'h3;
   wire [1:0] vec_ch = in_svc_r ? svc_ch_r : top_ch;
   wire [7:0] vec    = {bias_r, err_r[vec_ch], vec_ch};

   // channel arbitration, fixed priority, lowest channel first
   logic [3:0] runnable;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         runnable[i] = (ctl_r[i][1:0] != 2'h0) & ~gap_r[i]
                       & (req_in[i] | ctl_r[i][`DCV_B_AUTO]);
      end
   end
   wire [3:0] pick = runnable[0] ? 4'h1 : runnable[1] ? 4'h2 :
                     runnable[2] ? 4'h4 : runnable[3] ? 4'h8 : 4'h0;
   wire [1:0] act  = gnt_r[1] ? 2'h1 : gnt_r[2] ? 2'h2 : gnt_r[3] ? 2'h3 : 2'h0;
   wire [1:0] cmp  = act ^ 2'h1;
   wire       beat = xfer_done_in & (|gnt_r);

   // beat arithmetic for the active channel
   wire [23:0] ac     = ctl_r[act];
   wire [23:0] s_step = ac[`DCV_B_SRC_WIDTH] ? 24'h000002 : 24'h000001;
   wire [23:0] d_step = ac[`DCV_B_DST_WIDTH] ? 24'h000002 : 24'h000001;
   wire [15:0] c_step = (ac[`DCV_B_SRC_WIDTH] | ac[`DCV_B_DST_WIDTH])
                        ? 16'h0002 : 16'h0001;
   wire [23:0] src_mv = ac[`DCV_B_SRC_DOWN] ? src_r[act] - s_step
                                            : src_r[act] + s_step;
   wire [23:0] dst_mv = ac[`DCV_B_DST_DOWN] ? dst_r[act] - d_step
                                            : dst_r[act] + d_step;
   wire [15:0] cnt_mv = (cnt_r[act] <= c_step) ? 16'h0000
                                               : cnt_r[act] - c_step;
   wire        eq     = ((xfer_data_in ^ pat_r[act]) & msk_r[act]) == 8'h00;
   wire        pattern_value   = ac[0];
   wire        hit    = beat & pattern_value & (ac[`DCV_B_SENSE] ? ~eq : eq);
   wire        take   = ~hit | ac[`DCV_B_INCLUSIVE];
   wire        c_zero = take ? (cnt_mv == 16'h0000) : (cnt_r[act] == 16'h0000);
   wire [1:0]  hact   = ac[`DCV_B_ON_HIT +: 2];
   wire        h_cont = hact == dcv_pkg::HIT_CONTINUE;
   wire        done   = beat & ((hit & ~h_cont) | (~hit & c_zero)
                                | (hit & h_cont & c_zero));
   wire        l_ctl  = (hit & ~h_cont & hact[1]) | (~hit & done & ac[`DCV_B_ON_DONE]);
   wire        l_par  = (hit & hact == dcv_pkg::HIT_LOAD_ALL)
                        | (~hit & done & ac[`DCV_B_ON_DONE]);
   wire        stop   = done & ~l_ctl;
   wire [1:0]  hlt_ch = (|gnt_r) ? act : (pick[1] ? 2'h1 : pick[2] ? 2'h2 :
                                          pick[3] ? 2'h3 : 2'h0);
   // a halt pulse with no active or runnable channel touches nothing
   wire        hlt_any = halt_pls & ((|gnt_r) | (|pick));

   always_comb begin
      logic [2:0] ev;
      logic [3:0] nib;
      logic [3:0] clr;
      ev       = 3'h0;
      nib      = 4'h0;
      clr      = 4'h0;
      gnt_nxt  = gnt_r;
      gap_nxt  = 4'h0;
      bias_nxt = bias_r;
      cfg_nxt  = cfg_r;
      err_nxt  = err_r;
      flags_nxt = flags_r;
      for (int i = 0; i < 4; i++) begin
         ctl_nxt[i] = ctl_r[i];
         pat_nxt[i] = pat_r[i];
         msk_nxt[i] = msk_r[i];
         src_nxt[i] = src_r[i];
         dst_nxt[i] = dst_r[i];
         cnt_nxt[i] = cnt_r[i];
      end
      // software writes
      if (wr_hit & is_ack) begin
         bias_nxt = wdata_in[7:3];
      end
      if (wr_hit & is_cfg) begin
         cfg_nxt = wdata_in;
      end
      if (wr_hit & ~is_glob) begin
         case (a_sub)
            `DCV_OFF_CTL_LOW:  ctl_nxt[a_ch][7:0]   = wdata_in;
            `DCV_OFF_CTL_MID:  ctl_nxt[a_ch][15:8]  = wdata_in;
            `DCV_OFF_CTL_HIGH: ctl_nxt[a_ch][23:16] = {wdata_in[7:1], 1'b0};
            `DCV_OFF_PATTERN:  pat_nxt[a_ch] = wdata_in;
            `DCV_OFF_MASK:     msk_nxt[a_ch] = wdata_in;
            5'h0C, 5'h0D, 5'h0E: src_nxt[a_ch][8*(a_sub - `DCV_OFF_SRC_LO) +: 8] = wdata_in;
            5'h10, 5'h11, 5'h12: dst_nxt[a_ch][8*(a_sub - `DCV_OFF_DST_LO) +: 8] = wdata_in;
            5'h14, 5'h15: cnt_nxt[a_ch][8*(a_sub - `DCV_OFF_CNT_LO) +: 8] = wdata_in;
            default: ;
         endcase
      end
      // transfer beat on the granted channel
      if (beat) begin
         if (take) begin
            if (ac[`DCV_B_SRC_KIND]) begin
               src_nxt[act] = src_mv;
            end
            if (ac[`DCV_B_DST_KIND]) begin
               dst_nxt[act] = dst_mv;
            end
            cnt_nxt[act] = cnt_mv;
         end
         if (~ac[`DCV_B_BURST]) begin
            gap_nxt[act] = 1'b1;
         end
         if (l_ctl) begin
            ctl_nxt[act] = ctl_r[cmp];
         end
         if (l_par) begin
            src_nxt[act] = src_r[cmp];
            dst_nxt[act] = dst_r[cmp];
            cnt_nxt[act] = cnt_r[cmp];
         end
         if (stop) begin
            ctl_nxt[act][1:0] = 2'h0;
         end
      end
      if (hlt_any) begin
         ctl_nxt[hlt_ch][1:0] = 2'h0;
      end
      // grant follows arbitration; drops when the channel stops
      gnt_nxt = (beat & (stop | ~ac[`DCV_B_BURST])) ? 4'h0 : pick;
      if (halt_pls) begin
         gnt_nxt = 4'h0;
      end
      // event flags, one nibble per channel
      for (int i = 0; i < 4; i++) begin
         ev  = {hlt_any & (hlt_ch == 2'(i)),
                hit & (act == 2'(i)),
                done & (act == 2'(i))};
         nib = flags_r[4*i +: 4];
         clr = 4'h0;
         if (rd_hit & ((is_flo & i < 2) | (is_fhi & i >= 2))) begin
            clr = {~pend[i], ~ien[i]};
         end
         if (ack_rd & pend[i] & (top_ch == 2'(i))) begin
            clr         = 4'hF;
            err_nxt[i]  = 1'b0;
         end
         if (|(ev & ien[i]) & pend[i]) begin
            err_nxt[i] = 1'b1;
         end
         flags_nxt[4*i +: 4] = (nib & ~clr)
            | {((ev[0] + ev[1] + ev[2]) > 2'h1) | ((|ev) & (|nib[2:0])), ev};
      end
      if (soft_rst) begin
         bias_nxt  = `DCV_RST_BIAS;
         cfg_nxt   = `DCV_RST_CONFIG;
         err_nxt   = 4'h0;
         flags_nxt = 16'h0000;
         gnt_nxt   = 4'h0;
         for (int i = 0; i < 4; i++) begin
            ctl_nxt[i] = `DCV_RST_CTL;
            msk_nxt[i] = `DCV_RST_MASK;
         end
      end
   end

   // halt pin sequencer
   always_comb begin
      case (hs_r)
         dcv_pkg::HS_IDLE: hs_nxt = reset_halt_n_in ? dcv_pkg::HS_IDLE : dcv_pkg::HS_LOW1;
         dcv_pkg::HS_LOW1: hs_nxt = reset_halt_n_in ? dcv_pkg::HS_IDLE : dcv_pkg::HS_LOW2;
         dcv_pkg::HS_LOW2: hs_nxt = reset_halt_n_in ? dcv_pkg::HS_IDLE : dcv_pkg::HS_LONG;
         dcv_pkg::HS_LONG: hs_nxt = reset_halt_n_in ? dcv_pkg::HS_IDLE : dcv_pkg::HS_LONG;
         default:          hs_nxt = dcv_pkg::HS_IDLE;
      endcase
   end

   // read data mux
   logic [7:0] rmux;
   always_comb begin
      rmux = 8'h00;
      if (is_ack | is_peek) begin
         rmux = vec;
      end else if (is_cfg) begin
         rmux = cfg_r;
      end else if (is_flo) begin
         rmux = flags_r[7:0];
      end else if (is_fhi) begin
         rmux = flags_r[15:8];
      end else begin
         case (a_sub)
            `DCV_OFF_CTL_LOW:  rmux = ctl_r[a_ch][7:0];
            `DCV_OFF_CTL_MID:  rmux = ctl_r[a_ch][15:8];
            `DCV_OFF_CTL_HIGH: rmux = ctl_r[a_ch][23:16];
            `DCV_OFF_PATTERN:  rmux = pat_r[a_ch];
            `DCV_OFF_MASK:     rmux = msk_r[a_ch];
            5'h0C, 5'h0D, 5'h0E: rmux = src_r[a_ch][8*(a_sub - `DCV_OFF_SRC_LO) +: 8];
            5'h10, 5'h11, 5'h12: rmux = dst_r[a_ch][8*(a_sub - `DCV_OFF_DST_LO) +: 8];
            5'h14, 5'h15: rmux = cnt_r[a_ch][8*(a_sub - `DCV_OFF_CNT_LO) +: 8];
            default: rmux = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         for (int i = 0; i < 4; i++) begin
            ctl_r[i] <= `DCV_RST_CTL;
            pat_r[i] <= 8'h00;
            msk_r[i] <= `DCV_RST_MASK;
            src_r[i] <= 24'h000000;
            dst_r[i] <= 24'h000000;
            cnt_r[i] <= 16'h0000;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            ctl_r[i] <= ctl_nxt[i];
            pat_r[i] <= pat_nxt[i];
            msk_r[i] <= msk_nxt[i];
            src_r[i] <= src_nxt[i];
            dst_r[i] <= dst_nxt[i];
            cnt_r[i] <= cnt_nxt[i];
         end
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         flags_r <= 16'h0000;
         err_r   <= 4'h0;
         bias_r  <= `DCV_RST_BIAS;
         cfg_r   <= `DCV_RST_CONFIG;
         gnt_r   <= 4'h0;
         gap_r   <= 4'h0;
         hs_r    <= dcv_pkg::HS_IDLE;
      end else begin
         flags_r <= flags_nxt;
         err_r   <= err_nxt;
         bias_r  <= bias_nxt;
         cfg_r   <= cfg_nxt;
         gnt_r   <= gnt_nxt;
         gap_r   <= gap_nxt;
         hs_r    <= hs_nxt;
      end
   end

   // service flip-flop: acknowledge on odd reads, return on even reads
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         svc_ff_r <= 1'b0;
         in_svc_r <= 1'b0;
         svc_ch_r <= 2'h0;
      end else if (soft_rst | (wr_hit & is_ack)) begin
         svc_ff_r <= 1'b0;
         in_svc_r <= 1'b0;
      end else if (ack_rd) begin
         svc_ff_r <= 1'b1;
         in_svc_r <= 1'b1;
         svc_ch_r <= top_ch;
      end else if (ret_rd) begin
         svc_ff_r <= 1'b0;
         in_svc_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         rdat_r  <= 8'h00;
         irq_n_r <= 1'b1;
         src_q_r <= 24'h000000;
         dst_q_r <= 24'h000000;
      end else begin
         rdat_r  <= rd_hit ? rmux : 8'h00;
         irq_n_r <= ~|pend_nxt;
         src_q_r <= src_nxt[gnt_nxt[1] ? 1 : gnt_nxt[2] ? 2 : gnt_nxt[3] ? 3 : 0];
         dst_q_r <= dst_nxt[gnt_nxt[1] ? 1 : gnt_nxt[2] ? 2 : gnt_nxt[3] ? 3 : 0];
      end
   end

   assign rdata_out    = rdat_r;
   assign irq_n_out    = irq_n_r;
   assign chan_ack_out = gnt_r;
   assign src_addr_out = src_q_r;
   assign dst_addr_out = dst_q_r;
endmodule : dcv_dma_core
`default_nettype wire

// [bench/dcv_dma_core_properties.sv]
/*
 * Port checker for the DMA control and vectoring core.
 * Assumes one clock, reset_in asynchronous active high, bound below.
 */
`timescale 1ns/1ps
`default_nettype none
module dcv_dma_core_properties (
   input wire logic        mclk_in,
   input wire logic        reset_in,
   input wire logic        reset_halt_n_in,
   input wire logic        cs_n_in,
   input wire logic        rd_in,
   input wire logic        wr_in,
   input wire logic [6:0]  addr_in,
   input wire logic [7:0]  wdata_in,
   input wire logic [3:0]  req_in,
   input wire logic        xfer_done_in,
   input wire logic [7:0]  xfer_data_in,
   input wire logic [7:0]  rdata_out,
   input wire logic        irq_n_out,
   input wire logic [3:0]  chan_ack_out,
   input wire logic [23:0] src_addr_out,
   input wire logic [23:0] dst_addr_out
);
   logic [5:0] cause_r;
   logic       rd_any;
   logic       rd_ack;
   assign rd_any = !cs_n_in && rd_in;
   assign rd_ack = rd_any && addr_in == 7'h7C;

   // recent beats or halt-pin activity that may raise an event
   always_ff @(posedge mclk_in or posedge reset_in)
      if (reset_in) cause_r <= 6'h00;
      else cause_r <= {cause_r[4:0], xfer_done_in | !reset_halt_n_in};

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   a_read_idle_zero: assert property (!rd_any |=> rdata_out == 8'h00)
      else $error("read data not zero without a read");
   a_grant_onehot: assert property ($onehot0(chan_ack_out))
      else $error("more than one channel granted");
   a_long_halt_grant: assert property (!reset_halt_n_in [*5] |-> chan_ack_out == 4'h0)
      else $error("grant survives long halt pin");
   a_long_halt_irq: assert property (!reset_halt_n_in [*5] |-> irq_n_out)
      else $error("interrupt survives long halt pin");
   a_short_halt_stop: assert property (reset_halt_n_in && chan_ack_out != 4'h0 ##1
      !reset_halt_n_in ##1 reset_halt_n_in |-> ##[1:2] chan_ack_out == 4'h0)
      else $error("short halt did not stop channel");
   a_ptr_hold_idle: assert property ((chan_ack_out != 4'h0 && !xfer_done_in &&
      !(wr_in && !cs_n_in)) ##1 chan_ack_out == $past(chan_ack_out)
      |-> $stable(src_addr_out) && $stable(dst_addr_out))
      else $error("pointer moved without a beat");
   a_irq_rise_ack: assert property ($rose(irq_n_out) |-> $past(rd_ack) ||
      $past(rd_ack, 2) || $past(!reset_halt_n_in) || $past(!reset_halt_n_in, 2))
      else $error("interrupt released without acknowledge");
   a_irq_fall_cause: assert property ($fell(irq_n_out) |-> cause_r != 6'h00)
      else $error("interrupt raised without an event");

   c_beat: cover property (xfer_done_in && chan_ack_out != 4'h0);
   c_ack: cover property (rd_ack && !irq_n_out);
   c_halt: cover property (!reset_halt_n_in ##1 reset_halt_n_in);
endmodule : dcv_dma_core_properties

bind dcv_dma_core dcv_dma_core_properties u_props (
   .mclk_in(mclk_in), .reset_in(reset_in), .reset_halt_n_in(reset_halt_n_in),
   .cs_n_in(cs_n_in), .rd_in(rd_in), .wr_in(wr_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .req_in(req_in), .xfer_done_in(xfer_done_in),
   .xfer_data_in(xfer_data_in), .rdata_out(rdata_out), .irq_n_out(irq_n_out),
   .chan_ack_out(chan_ack_out), .src_addr_out(src_addr_out), .dst_addr_out(dst_addr_out)
);
`default_nettype wire

// [bench/dcv_xfer_model.sv]
/*
 * Transfer engine and peripheral model: answers a grant with one beat.
 * Assumes grant drops one cycle after a single-mode beat.
 */
`timescale 1ns/1ps
`default_nettype none
module dcv_xfer_model (
   input  wire logic       mclk_in,
   input  wire logic       reset_in,
   input  wire logic [3:0] chan_ack_in,
   input  wire logic [3:0] lat_in,
   input  wire logic [7:0] beat_data_in,
   output logic            xfer_done_out,
   output logic      [7:0] xfer_data_out
);
   logic [3:0] wait_r;
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         xfer_done_out <= 1'b0;
         xfer_data_out <= 8'hA5;
         wait_r        <= 4'h0;
      end else begin
         xfer_done_out <= 1'b0;
         // released data lines wander every cycle
         xfer_data_out <= ~xfer_data_out;
         if (chan_ack_in != 4'h0 && !xfer_done_out) begin
            if (wait_r >= lat_in) begin
               xfer_done_out <= 1'b1;
               xfer_data_out <= beat_data_in;
               wait_r        <= 4'h0;
            end else wait_r <= wait_r + 4'h1;
         end else wait_r <= 4'h0;
      end
   end
endmodule : dcv_xfer_model
`default_nettype wire

// [bench/dcv_dma_core_tb.sv]
/*
 * Self-checking bench for the DMA control and vectoring core.
 * Assumes dcv_regs.svh on the include path and the transfer model.
 */
`timescale 1ns/1ps
`default_nettype none
module dcv_dma_core_tb;
   logic        mclk = 1'b0, rst = 1'b1, rhn = 1'b1, cs_n = 1'b1, rd = 1'b0, wr = 1'b0;
   logic [6:0]  addr = 7'h00;
   logic [7:0]  wdata = 8'h00, pat = 8'h00, v;
   logic [3:0]  req = 4'h0, lat = 4'h1;
   wire logic        xdone, irq_n;
   wire logic [7:0]  xdata, rdata;
   wire logic [3:0]  ack;
   wire logic [23:0] src, dst;
   int fail_count = 0, checked = 0, beats = 0;

   always #12.5 mclk = ~mclk;
   always @(posedge mclk) if (xdone === 1'b1) beats++;

   dcv_dma_core dut (.mclk_in(mclk), .reset_in(rst), .reset_halt_n_in(rhn), .cs_n_in(cs_n),
      .rd_in(rd), .wr_in(wr), .addr_in(addr), .wdata_in(wdata), .req_in(req),
      .xfer_done_in(xdone), .xfer_data_in(xdata), .rdata_out(rdata), .irq_n_out(irq_n),
      .chan_ack_out(ack), .src_addr_out(src), .dst_addr_out(dst));
   dcv_xfer_model peer (.mclk_in(mclk), .reset_in(rst), .chan_ack_in(ack), .lat_in(lat),
      .beat_data_in(pat), .xfer_done_out(xdone), .xfer_data_out(xdata));

   task summarize;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize

   task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task acc(input logic [6:0] a, input logic [7:0] d, input logic w);
      @(posedge mclk);
      cs_n <= 1'b0; addr <= a; wdata <= d; wr <= w; rd <= !w;
      @(posedge mclk);
      cs_n <= 1'b1; wr <= 1'b0; rd <= 1'b0;
      #1 v = rdata;
   endtask : acc

   task rdchk(input string n, input logic [6:0] a, input logic [7:0] e);
      acc(a, 8'h00, 1'b0);
      check(n, v, e);
   endtask : rdchk

   task prog(input logic [1:0] ch, input logic [7:0] lo, mi, hi, input logic [23:0] s, d,
             input logic [15:0] n);
      logic [6:0] b;
      b = {ch, 5'h00};
      acc(b + 7'h01, mi, 1'b1);
      acc(b + 7'h02, hi, 1'b1);
      for (int i = 0; i < 3; i++) begin
         acc(b + 7'h0C + 7'(i), s[8*i +: 8], 1'b1);
         acc(b + 7'h10 + 7'(i), d[8*i +: 8], 1'b1);
      end
      acc(b + 7'h14, n[7:0], 1'b1);
      acc(b + 7'h15, n[15:8], 1'b1);
      acc(b, lo, 1'b1);
   endtask : prog

   task wait_irq(input logic lvl);
      for (int i = 0; i < 300 && irq_n !== lvl; i++) @(posedge mclk);
      if (irq_n !== lvl) begin
         fail_count++;
         $display("unexpected irq_n: expected %b seen %b", lvl, irq_n);
         summarize();
      end
   endtask : wait_irq

   task timed_out(input string what);
      fail_count++;
      $display("unexpected %s: expected event seen timeout", what);
      summarize();
   endtask : timed_out

   task t_reset;
      rdchk("ctl low", 7'h00, 8'h00);
      rdchk("mask", 7'h48, 8'h00);
      rdchk("flags", 7'h7E, 8'h00);
      acc(7'h1F, 8'h5A, 1'b1);
      rdchk("unmapped", 7'h1F, 8'h00);
      acc(7'h22, 8'hFF, 1'b1);
      rdchk("ctl high", 7'h22, 8'hFE);
      acc(7'h22, 8'h00, 1'b1);
   endtask : t_reset

   task t_move;
      acc(7'h7C, 8'hA8, 1'b1);
      for (int w = 0; w < 2; w++) begin
         beats = 0;
         @(posedge mclk);
         req <= 4'h1;
         prog(2'd0, 8'h02, w ? 8'hD5 : 8'h01, 8'h20, 24'h001000, 24'h00ABCD, 16'h0004);
         wait_irq(1'b0);
         req <= 4'h0;
         check("beats", 24'(beats), w ? 24'd2 : 24'd4);
         rdchk("src", 7'h0C, 8'h04);
         rdchk("dst", 7'h10, w ? 8'hC9 : 8'hCD);
         rdchk("dst mid", 7'h11, 8'hAB);
         rdchk("count", 7'h14, 8'h00);
         rdchk("flags", 7'h7E, 8'h01);
         rdchk("flags kept", 7'h7E, 8'h01);
         rdchk("peek", 7'h5C, 8'hA8);
         check("irq after peek", irq_n, 1'b0);
         rdchk("vector", 7'h7C, 8'hA8);
         @(posedge mclk);
         #1 check("irq after ack", irq_n, 1'b1);
         acc(7'h7C, 8'h00, 1'b0);
         rdchk("flags acked", 7'h7E, 8'h00);
      end
   endtask : t_move

   task t_events;
      beats = 0;
      @(posedge mclk);
      req <= 4'h2;
      prog(2'd1, 8'h02, 8'h01, 8'h20, 24'h000100, 24'h000200, 16'h0001);
      wait_irq(1'b0);
      prog(2'd1, 8'h02, 8'h01, 8'h20, 24'h000100, 24'h000200, 16'h0001);
      for (int i = 0; i < 100 && beats < 2; i++) @(posedge mclk);
      if (beats < 2) timed_out("second beat");
      repeat (4) @(posedge mclk);
      rdchk("vector twice", 7'h7C, 8'hAD);
      acc(7'h7C, 8'h00, 1'b0);
      prog(2'd1, 8'h02, 8'h01, 8'h00, 24'h000100, 24'h000200, 16'h0001);
      v = 8'h00;
      for (int i = 0; i < 50 && v === 8'h00; i++) acc(7'h7E, 8'h00, 1'b0);
      if (v === 8'h00) timed_out("quiet flags");
      check("quiet flags", v, 8'h10);
      rdchk("quiet cleared", 7'h7E, 8'h00);
      check("quiet irq", irq_n, 1'b1);
      @(posedge mclk);
      req <= 4'h0;
   endtask : t_events

   task t_search;
      @(posedge mclk);
      pat <= 8'h35;
      acc(7'h44, 8'h3C, 1'b1);
      acc(7'h48, 8'hF0, 1'b1);
      @(posedge mclk);
      req <= 4'h4;
      prog(2'd2, 8'h01, 8'h01, 8'h40, 24'h000300, 24'h000400, 16'h0008);
      wait_irq(1'b0);
      req <= 4'h0;
      rdchk("hit flags", 7'h7F, 8'h0B);
      rdchk("hit vector", 7'h7C, 8'hAA);
      acc(7'h7C, 8'h00, 1'b0);
   endtask : t_search

   task t_halt;
      @(posedge mclk);
      lat <= 4'h6;
      req <= 4'h8;
      prog(2'd3, 8'h02, 8'h01, 8'h80, 24'h000500, 24'h000600, 16'h0100);
      for (int i = 0; i < 50 && ack !== 4'h8; i++) @(posedge mclk);
      if (ack !== 4'h8) timed_out("grant");
      #1 check("src out", src, 24'h000500);
      check("dst out", dst, 24'h000600);
      // request stays up so the pulse finds the channel still granted
      @(posedge mclk);
      rhn <= 1'b0;
      @(posedge mclk);
      rhn <= 1'b1;
      wait_irq(1'b0);
      rdchk("halt flags", 7'h7F, 8'h40);
      rdchk("halt vector", 7'h7C, 8'hAB);
      acc(7'h7C, 8'h00, 1'b0);
      // software stops an indirect transfer by clearing the op code
      prog(2'd3, 8'h02, 8'h01, 8'h00, 24'h000500, 24'h000600, 16'h0100);
      acc(7'h60, 8'h00, 1'b1);
      repeat (10) @(posedge mclk);
      req <= 4'h0;
      rdchk("stopped count", 7'h75, 8'h01);
      check("stopped grant", ack, 4'h0);
      acc(7'h08, 8'hFF, 1'b1);
      @(posedge mclk);
      rhn <= 1'b0;
      repeat (6) @(posedge mclk);
      rhn <= 1'b1;
      rdchk("mask cleared", 7'h08, 8'h00);
      rdchk("ctl cleared", 7'h02, 8'h00);
   endtask : t_halt

   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_move();
      t_events();
      t_search();
      t_halt();
      summarize();
   end
endmodule : dcv_dma_core_tb
`default_nettype wire
